// ---- kwu_top.sv ----
// Purpose: two 8-bit ports with key wake-up and start detection
// Assumes: Avalon-MM slave, byte address, one register per word
// Notes: stop_mode comes from clk-domain power control logic
`timescale 1ns/1ps

// Contract
// R1: every wake-capable pin sets its flag on a falling edge
// R2: interrupt request when a flag and its enable are both set
// R3: fifteen sources share one request; first port bit 6 does start detect
// R4: edge detection works with the pin as input or output
// R5: in stop, enabled pins reach the wake request with no clocked path
// R6: bias select pin high gives pull-ups, low gives pull-downs
// R7: direction 0 is input, 1 is output; second port resets to input
// R8: data, direction, enable and flag registers read and write anytime
// R9: select 0 gives plain edge on bit 6; 1 gives start detect
// R10: with start detect, bits 6 and 7 are open-drain
// R11: with start detect, SDA fall counts only while SCL high
// R12: enable and flag bit 6 follow the start detect selection
// R13: enables gate the matching interrupt, 0 off and 1 on
// R14: writing one clears a flag, writing zero leaves it
// R15: first port flag bit 7 always reads zero
// R16: input filter acts only in stop mode
// R17: filter oscillator starts on an enabled triggering edge
// R18: three samples per period; two low votes set the flag
// R19: one filter shared by every enabled wake input
// R20: pulses closer than minimum spacing may merge into one
// R21: software keeps every pin driven or biased
// R22: outside stop a synchronised falling edge sets the flag directly
module kwu_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // first port pins
  input wire logic [7:0] first_port_in,
  output logic [7:0] first_port_out,
  output logic [7:0] first_port_oe,
  // second port pins
  input wire logic [7:0] second_port_in,
  output logic [7:0] second_port_out,
  output logic [7:0] second_port_oe,
  // bias select pins and pad bias controls
  input wire logic first_port_bias_select,
  input wire logic second_port_bias_select,
  output logic [7:0] first_port_pull_up,
  output logic [7:0] first_port_pull_down,
  output logic [7:0] second_port_pull_up,
  output logic [7:0] second_port_pull_down,
  // power state and wake outputs
  input wire logic stop_mode,
  output logic wake_irq,
  output logic stop_wake_req
);
  import kwu_pkg::*;

  // registers
  logic [7:0] g_data_reg;
  logic [7:0] h_data_reg;
  logic [7:0] g_dir_reg;
  logic [7:0] h_dir_reg;
  logic [7:0] g_wen_reg;
  logic [7:0] h_wen_reg;
  logic [7:0] g_wfl_reg;
  logic [7:0] h_wfl_reg;
  logic [7:0] g_wfl_next;
  logic [7:0] h_wfl_next;

  // stop-mode capture of edges awaiting the filter verdict
  logic [7:0] g_pend_reg;
  logic [7:0] h_pend_reg;

  // synchronised pins and their previous sample
  logic [17:0] sync_q;
  logic [7:0] g_prev_reg;
  logic [7:0] h_prev_reg;

  // bus handshake
  logic wait_reg;

  // filter result
  logic filt_done;
  logic filt_valid;

  // pin level synchronisers, bias selects ride along
  kwu_sync #(
    .W(18)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({second_port_bias_select, first_port_bias_select,
        second_port_in, first_port_in}),
    .q(sync_q)
  );

  wire [7:0] g_s = sync_q[7:0];
  wire [7:0] h_s = sync_q[15:8];
  wire g_bias = sync_q[16];
  wire h_bias = sync_q[17];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      g_prev_reg <= 8'hFF;
      h_prev_reg <= 8'hFF;
    end else begin
      g_prev_reg <= g_s;
      h_prev_reg <= h_s;
    end
  end

  // edge detection reads the pad input, so it works for outputs too
  wire [7:0] g_fall = g_prev_reg & ~g_s; // R1 R4
  wire [7:0] h_fall = h_prev_reg & ~h_s; // R1 R4

  wire sds = g_wen_reg[SDS_BIT];
  wire scl_high = g_s[SCL_BIT];

  // bit 6 turns into a start detector; bit 7 never flags
  wire sda_event = g_fall[SDA_BIT] & (~sds | scl_high); // R9 R11 R12
  wire [7:0] g_edge = {1'b0, sda_event, g_fall[5:0]}; // R3 R15
  wire [7:0] h_edge = h_fall;

  // enables, bit 7 of the first port is the mode select, not an enable
  wire [7:0] g_en = {1'b0, g_wen_reg[6:0]}; // R13
  wire [7:0] h_en = h_wen_reg; // R13

  // stop-mode filter path
  wire [7:0] g_trig = g_edge & g_en;
  wire [7:0] h_trig = h_edge & h_en;
  wire any_trig = |{g_trig, h_trig};

  // any enabled pin at the low level feeds the one shared vote
  wire any_low = |{g_en & ~g_s, h_en & ~h_s}; // R19

  kwu_filter u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .run(stop_mode), // R16
    .start(any_trig), // R17
    .level(any_low),
    .done(filt_done),
    .valid(filt_valid)
  );

  // edges inside one filter period are merged into one verdict
  always_ff @(posedge clk) begin
    if (!rst_b || !stop_mode || filt_done) begin
      g_pend_reg <= 8'h00;
      h_pend_reg <= 8'h00;
    end else begin
      g_pend_reg <= g_pend_reg | g_trig; // R20
      h_pend_reg <= h_pend_reg | h_trig; // R20
    end
  end

  wire filt_ok = filt_done & filt_valid;
  wire [7:0] g_pend_all = g_pend_reg | g_trig;
  wire [7:0] h_pend_all = h_pend_reg | h_trig;

  // in stop only a filter pass sets flags; otherwise edges set them
  wire [7:0] g_set = stop_mode ? (filt_ok ? g_pend_all : 8'h00) : g_edge; // R16 R18 R22
  wire [7:0] h_set = stop_mode ? (filt_ok ? h_pend_all : 8'h00) : h_edge; // R16 R18 R22

  // bus decode
  wire [5:0] idx = address[7:2];
  wire lane0 = byteenable[0];
  wire bus_req = read | write;
  wire wr_take = write & ~wait_reg & lane0;
  wire [7:0] wbyte = writedata[7:0];

  wire hit_g_data = (idx == IDX_G_DATA);
  wire hit_h_data = (idx == IDX_H_DATA);
  wire hit_g_dir = (idx == IDX_G_DIR);
  wire hit_h_dir = (idx == IDX_H_DIR);
  wire hit_g_wen = (idx == IDX_G_WEN);
  wire hit_h_wen = (idx == IDX_H_WEN);
  wire hit_g_wfl = (idx == IDX_G_WFL);
  wire hit_h_wfl = (idx == IDX_H_WFL);

  // write-one-to-clear, a set in the same cycle wins over the clear
  wire [7:0] g_clr = (wr_take & hit_g_wfl) ? wbyte : 8'h00; // R14
  wire [7:0] h_clr = (wr_take & hit_h_wfl) ? wbyte : 8'h00; // R14

  assign g_wfl_next = ((g_wfl_reg & ~g_clr) | g_set) & 8'h7F; // R1 R14 R15
  assign h_wfl_next = (h_wfl_reg & ~h_clr) | h_set; // R1 R14

  // port data reads the pin when input, the latch when output
  wire [7:0] g_rd_data = (g_dir_reg & g_data_reg) | (~g_dir_reg & g_s);
  wire [7:0] h_rd_data = (h_dir_reg & h_data_reg) | (~h_dir_reg & h_s);

  wire [7:0] rd_byte =
    hit_g_data ? g_rd_data :
    hit_h_data ? h_rd_data :
    hit_g_dir ? g_dir_reg :
    hit_h_dir ? h_dir_reg :
    hit_g_wen ? g_wen_reg :
    hit_h_wen ? h_wen_reg :
    hit_g_wfl ? g_wfl_reg :
    hit_h_wfl ? h_wfl_reg : 8'h00; // R8 R15

  // one wait cycle per access; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_reg <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (read & wait_reg) readdata <= {24'h000000, rd_byte};
    end
  end

  assign waitrequest = wait_reg;

  // register writes, accepted at any time
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      g_data_reg <= RST_DATA;
      h_data_reg <= RST_DATA;
      g_dir_reg <= RST_DIR;
      h_dir_reg <= RST_DIR; // R7
      g_wen_reg <= RST_WEN;
      h_wen_reg <= RST_WEN;
    end else if (wr_take) begin
      if (hit_g_data) g_data_reg <= wbyte; // R8
      if (hit_h_data) h_data_reg <= wbyte; // R8
      if (hit_g_dir) g_dir_reg <= wbyte; // R8
      if (hit_h_dir) h_dir_reg <= wbyte; // R8
      if (hit_g_wen) g_wen_reg <= wbyte; // R8
      if (hit_h_wen) h_wen_reg <= wbyte; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      g_wfl_reg <= RST_WFL;
      h_wfl_reg <= RST_WFL;
    end else begin
      g_wfl_reg <= g_wfl_next;
      h_wfl_reg <= h_wfl_next;
    end
  end

  // single shared request for all fifteen sources
  wire irq_next = |{g_wfl_reg & g_en, h_wfl_reg & h_en}; // R2 R3 R13

  always_ff @(posedge clk) begin
    if (!rst_b) wake_irq <= 1'b0;
    else wake_irq <= irq_next;
  end

  // the clock may be stopped, so this request bypasses every flop:
  // an enabled pin held low in stop asserts it directly
  wire [7:0] g_low_raw = g_en & ~first_port_in;
  wire [7:0] h_low_raw = h_en & ~second_port_in;
  assign stop_wake_req = stop_mode & (|{g_low_raw, h_low_raw}); // R5

  // pad drivers; start detect turns bits 6 and 7 into open drain
  wire [7:0] od_mask = sds ? 8'hC0 : 8'h00; // R10
  wire [7:0] g_out_next = g_data_reg & ~od_mask; // R10
  wire [7:0] g_oe_next = (g_dir_reg & ~od_mask) |
                         (g_dir_reg & od_mask & ~g_data_reg); // R7 R10
  wire [7:0] h_out_next = h_data_reg;
  wire [7:0] h_oe_next = h_dir_reg; // R7

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_port_out <= 8'h00;
      first_port_oe <= 8'h00;
      second_port_out <= 8'h00;
      second_port_oe <= 8'h00;
    end else begin
      first_port_out <= g_out_next;
      first_port_oe <= g_oe_next;
      second_port_out <= h_out_next;
      second_port_oe <= h_oe_next;
    end
  end

  // bias only matters on undriven pins, so driven pins get none;
  // pins left neither driven nor biased float, software avoids that
  wire [7:0] g_in_mask = ~g_oe_next;
  wire [7:0] h_in_mask = ~h_oe_next;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_port_pull_up <= 8'h00;
      first_port_pull_down <= 8'h00;
      second_port_pull_up <= 8'h00;
      second_port_pull_down <= 8'h00;
    end else begin
      first_port_pull_up <= g_in_mask & {8{g_bias}}; // R6 R21
      first_port_pull_down <= g_in_mask & {8{~g_bias}}; // R6
      second_port_pull_up <= h_in_mask & {8{h_bias}}; // R6 R21
      second_port_pull_down <= h_in_mask & {8{~h_bias}}; // R6
    end
  end

endmodule // kwu_top

// ---- kwu_pkg.sv ----
// Purpose: shared constants for the key wake-up port block
// Assumes: 125 MHz bus clock, Avalon-MM word-per-register map
// Notes: register byte address is four times the register index
package kwu_pkg;

  // register indices, byte address = index * 4
  localparam logic [5:0] IDX_G_DATA = 6'h28;
  localparam logic [5:0] IDX_H_DATA = 6'h29;
  localparam logic [5:0] IDX_G_DIR = 6'h2A;
  localparam logic [5:0] IDX_H_DIR = 6'h2B;
  localparam logic [5:0] IDX_G_WEN = 6'h2C;
  localparam logic [5:0] IDX_H_WEN = 6'h2D;
  localparam logic [5:0] IDX_G_WFL = 6'h2E;
  localparam logic [5:0] IDX_H_WFL = 6'h2F;

  // reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_WEN = 8'h00;
  localparam logic [7:0] RST_WFL = 8'h00;

  // field positions in the first port
  localparam int SDA_BIT = 6;
  localparam int SCL_BIT = 7;
  localparam int SDS_BIT = 7;

  // filter oscillator timing
  localparam int CLK_MHZ = 125;
  localparam int FILT_OSC_NS = 200;
  localparam int FILT_PERIOD = (FILT_OSC_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] FILT_S1 = 8'(FILT_PERIOD / 4);
  localparam logic [7:0] FILT_S2 = 8'(FILT_PERIOD / 2);
  localparam logic [7:0] FILT_S3 = 8'((3 * FILT_PERIOD) / 4);
  localparam logic [7:0] FILT_LAST = 8'(FILT_PERIOD - 1);

  typedef enum logic {
    KWU_FLT_IDLE = 1'b0,
    KWU_FLT_RUN = 1'b1
  } kwu_flt_t;

endpackage

// ---- kwu_sync.sv ----
// Purpose: two-stage synchroniser for pin-side levels
// Assumes: inputs are asynchronous to clk
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module kwu_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= '1;
      q <= '1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // kwu_sync

// ---- kwu_filter.sv ----
// Purpose: shared majority-vote wake-up filter
// Assumes: oscillator period derived from clk by counting
// Notes: one period of three votes per start, then idle again
`timescale 1ns/1ps
module kwu_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic start,
  input wire logic level,
  // result
  output logic done,
  output logic valid
);
  import kwu_pkg::*;

  kwu_flt_t state_reg;
  logic [7:0] cnt_reg;
  logic [1:0] votes_reg;
  wire sample = (cnt_reg == FILT_S1) || (cnt_reg == FILT_S2) || (cnt_reg == FILT_S3);
  wire last = (cnt_reg == FILT_LAST);

  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      state_reg <= KWU_FLT_IDLE;
      cnt_reg <= 8'h00;
      votes_reg <= 2'h0;
      done <= 1'b0;
      valid <= 1'b0;
    end else begin
      done <= 1'b0;
      valid <= 1'b0;
      unique case (state_reg)
        KWU_FLT_IDLE: begin
          cnt_reg <= 8'h00;
          votes_reg <= 2'h0;
          if (start) state_reg <= KWU_FLT_RUN; // R17
        end
        KWU_FLT_RUN: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (sample && level) votes_reg <= votes_reg + 2'h1; // R18
          if (last) begin
            done <= 1'b1;
            valid <= votes_reg[1]; // R18
            state_reg <= KWU_FLT_IDLE;
          end
        end
      endcase
    end
  end
endmodule // kwu_filter

// ---- kwu_pins.sv ----
// Purpose: board-side model of switches on both port pads
// Assumes: every pad has a switch level behind it
// Notes: a pad driven by the port shows the port level
`timescale 1ns/1ps
module kwu_pins (
  // port pad drive
  out,
  oe,
  // board switches
  sw,
  // resolved pad level
  pad
);
  input wire logic [7:0] out;
  input wire logic [7:0] oe;
  input wire logic [7:0] sw;
  output logic [7:0] pad;
  // switches always drive, so no pad is left floating
  assign pad = (oe & out) | (~oe & sw);
endmodule // kwu_pins

// ---- kwu_assertions.sv ----
// Purpose: port-level checker for the key wake-up block
// Assumes: one clock domain, synchronous active-low reset
// Notes: pad output timing follows the register write by two edges
`timescale 1ns/1ps
module kwu_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pads
  input wire logic [7:0] second_port_out,
  input wire logic [7:0] second_port_oe,
  input wire logic [7:0] first_port_pull_up,
  input wire logic [7:0] first_port_pull_down,
  input wire logic [7:0] second_port_pull_up,
  input wire logic [7:0] second_port_pull_down,
  // pad levels
  input wire logic [7:0] first_port_in,
  input wire logic [7:0] second_port_in,
  // power
  input wire logic stop_mode,
  input wire logic stop_wake_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_take; (read || write) && !waitrequest; endsequence
  sequence s_wr(a); write && !waitrequest && byteenable[0] && address == a; endsequence
  property p_ans; s_req |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer after one wait");
  property p_one; s_take |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_flag7; read && !waitrequest && address == 8'hB8 |-> !readdata[7]; endproperty
  a_flag7: assert property (p_flag7) else $error("flag bit 7 read as one");
  property p_oe; s_wr(8'hAC) |-> ##2 second_port_oe == $past(writedata[7:0], 2); endproperty
  a_oe: assert property (p_oe) else $error("direction not on pad enable");
  property p_out; s_wr(8'hA4) |-> ##2 second_port_out == $past(writedata[7:0], 2); endproperty
  a_out: assert property (p_out) else $error("data not on pad output");
  property p_wake;
    stop_wake_req |-> stop_mode && (first_port_in != 8'hFF || second_port_in != 8'hFF);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request outside stop");
  property p_pull_g; (first_port_pull_up & first_port_pull_down) == 8'h00; endproperty
  a_pull_g: assert property (p_pull_g) else $error("first port pulled both ways");
  property p_pull_h; (second_port_pull_up & second_port_pull_down) == 8'h00; endproperty
  a_pull_h: assert property (p_pull_h) else $error("second port pulled both ways");
endmodule // kwu_checker
bind kwu_top kwu_checker chk_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .second_port_out(second_port_out),
  .second_port_oe(second_port_oe), .first_port_pull_up(first_port_pull_up),
  .first_port_pull_down(first_port_pull_down), .second_port_pull_up(second_port_pull_up),
  .second_port_pull_down(second_port_pull_down), .first_port_in(first_port_in),
  .second_port_in(second_port_in), .stop_mode(stop_mode),
  .stop_wake_req(stop_wake_req));

// ---- tb_key_wakeup_ports.sv ----
// Purpose: register and pin tests for the key wake-up block
// Assumes: one wait cycle per bus access, flags settle within 8 edges outside stop
// Notes: pin pulses are spaced far apart so the filter never merges them
`timescale 1ns/1ps
module tb_key_wakeup_ports;
  logic clk = 0, rst_b = 0, read = 0, write = 0, stop_mode = 0, gb = 0, hb = 1;
  logic [7:0] address = 8'h00, g_sw = 8'hFF, h_sw = 8'hFF;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0] be = 4'hF;
  logic waitrequest, wake_irq, stop_wake_req;
  logic [7:0] g_out, g_oe, g_pu, g_pd, g_pad, h_out, h_oe, h_pu, h_pd, h_pad;
  logic [7:0] ra [3] = '{8'hA8, 8'hAC, 8'hB4};
  int mismatches = 0, samples_checked = 0, cyc = 0;
  always #4 clk = ~clk;
  kwu_top dut_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .first_port_in(g_pad), .first_port_out(g_out),
    .first_port_oe(g_oe), .second_port_in(h_pad), .second_port_out(h_out),
    .second_port_oe(h_oe), .first_port_bias_select(gb), .second_port_bias_select(hb),
    .first_port_pull_up(g_pu), .first_port_pull_down(g_pd), .second_port_pull_up(h_pu),
    .second_port_pull_down(h_pd), .stop_mode(stop_mode), .wake_irq(wake_irq),
    .stop_wake_req(stop_wake_req));
  kwu_pins g_u (.out(g_out), .oe(g_oe), .sw(g_sw), .pad(g_pad));
  kwu_pins h_u (.out(h_out), .oe(h_oe), .sw(h_sw), .pad(h_pad));
  task report_and_stop;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // holds the request until the edge that sees waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    if (!w) chk(readdata, {24'h0, d});
    read <= 0;
    write <= 0;
    @(posedge clk);
  endtask
  task pins(input logic [7:0] g, input logic [7:0] h, input int n);
    g_sw <= g;
    h_sw <= h;
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    bus(0, 8'hAC, 8'h00);
    foreach (ra[i]) begin
      bus(1, ra[i], 8'h5A);
      bus(0, ra[i], 8'h5A);
      bus(1, ra[i], 8'h00);
    end
    // setting a direction bit high with data zero on a high switch is a falling edge too
    bus(0, 8'hB8, 8'h5A);
    bus(0, 8'hBC, 8'h5A);
    bus(1, 8'hB8, 8'hFF);
    bus(1, 8'hBC, 8'hFF);
    bus(1, 8'hC0, 8'h77);
    bus(0, 8'hC0, 8'h00);
    be <= 4'hE;
    bus(1, 8'hA8, 8'h33);
    be <= 4'hF;
    bus(0, 8'hA8, 8'h00);
    chk(g_pd, 8'hFF);
    chk(h_pu, 8'hFF);
    pins(8'hFF, 8'hF7, 8);
    bus(0, 8'hBC, 8'h08);
    chk(wake_irq, 1'b0);
    bus(1, 8'hB4, 8'h08);
    @(posedge clk);
    chk(wake_irq, 1'b1);
    bus(1, 8'hBC, 8'h00);
    bus(0, 8'hBC, 8'h08);
    bus(1, 8'hBC, 8'h08);
    bus(0, 8'hBC, 8'h00);
    chk(wake_irq, 1'b0);
    pins(8'hFF, 8'hFF, 8);
    bus(1, 8'hA4, 8'h01);
    bus(1, 8'hAC, 8'h01);
    @(posedge clk);
    chk(h_oe, 8'h01);
    bus(1, 8'hA4, 8'h00);
    repeat (8) @(posedge clk);
    bus(0, 8'hBC, 8'h01);
    bus(0, 8'hA4, 8'hFE);
    bus(1, 8'hAC, 8'h00);
    bus(1, 8'hBC, 8'hFF);
    pins(8'h7F, 8'hFF, 8);
    bus(0, 8'hB8, 8'h00);
    pins(8'h3F, 8'hFF, 8);
    bus(0, 8'hB8, 8'h40);
    bus(1, 8'hB8, 8'hFF);
    pins(8'hFF, 8'hFF, 8);
    bus(1, 8'hB0, 8'h80);
    pins(8'h7F, 8'hFF, 8);
    pins(8'h3F, 8'hFF, 8);
    bus(0, 8'hB8, 8'h00);
    pins(8'hFF, 8'hFF, 8);
    pins(8'hBF, 8'hFF, 8);
    bus(0, 8'hB8, 8'h40);
    bus(1, 8'hA8, 8'hC0);
    bus(1, 8'hA0, 8'h80);
    @(posedge clk);
    chk({g_out[7:6], g_oe[7:6]}, 4'h1);
    bus(1, 8'hB0, 8'h00);
    bus(1, 8'hA8, 8'h00);
    gb <= 1;
    pins(8'hFF, 8'hFF, 8);
    chk(g_pu, 8'hFF);
    bus(1, 8'hB8, 8'hFF);
    bus(1, 8'hB4, 8'h01);
    stop_mode <= 1;
    pins(8'hFF, 8'hFE, 1);
    chk(stop_wake_req, 1'b1);
    pins(8'hFF, 8'hFE, 40);
    bus(0, 8'hBC, 8'h01);
    pins(8'hFF, 8'hFF, 8);
    bus(1, 8'hBC, 8'hFF);
    pins(8'hFF, 8'hFC, 2);
    pins(8'hFF, 8'hFD, 40);
    bus(0, 8'hBC, 8'h00);
    stop_mode <= 0;
    report_and_stop;
  end
endmodule // tb_key_wakeup_ports
